// File: shared/dcmb_pkg.sv
// package: command mailbox constants, codes and state types
package dcmb_pkg;
  localparam logic [3:0] OFS_CMD = 4'h0;
  localparam logic [3:0] OFS_AUX = 4'h2;
  localparam logic [3:0] OFS_PTR = 4'h4;
  localparam logic [3:0] OFS_PTR_LO = 4'h6;
  localparam logic [3:0] OFS_DST = 4'h8;
  localparam logic [3:0] OFS_DST_LO = 4'hA;
  localparam logic [3:0] OFS_LUN = 4'hC;
  localparam logic [7:0] OP_GET_UNIT = 8'h46;
  localparam logic [7:0] OP_RUN_PROG = 8'h50;
  localparam logic [7:0] OP_BACKUP = 8'h55;
  localparam logic [7:0] OP_FLUSH = 8'h56;
  localparam logic [7:0] OP_FORMAT = 8'h57;
  localparam logic [7:0] OP_FORMAT_FLOPPY_TRACK = 8'h58;
  localparam logic [7:0] OP_COMPARE = 8'h59;
  localparam logic [7:0] OP_LOCK = 8'h5A;
  localparam logic [7:0] OP_RELEASE = 8'h5B;
  localparam logic [15:0] ST_OK = 16'h8000;
  localparam logic [15:0] ST_ADDR = 16'h8002;
  localparam logic [15:0] ST_PARAM = 16'h8006;
  localparam logic [15:0] ST_EXT = 16'h800F;
  localparam logic [15:0] ST_BANK = 16'h1000;
  localparam logic [15:0] ST_PAUSE = 16'h8000;
  localparam logic [3:0] BANK_POS = 4'hC;
  localparam logic [2:0] SIZE_CODE_MAX = 3'h3;
  localparam logic [7:0] DENS_MAX = 8'h01;
  localparam logic [7:0] ILV_USER = 8'h08;
  localparam logic [7:0] ILV_USER_OFS = 8'h0A;
  localparam logic [7:0] LOW_SEC_MAX = 8'h01;
  localparam logic [4:0] LOCK_ALL = 5'h01;
  localparam logic [3:0] FLOPPY_COUNT = 4'h4;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_FETCH = 8'h02,
    ST_DISPATCH = 8'h04,
    ST_WAIT_JOB = 8'h08,
    ST_RESULT = 8'h10,
    ST_STATUS = 8'h20,
    ST_PAUSED = 8'h40,
    ST_FLUSHB = 8'h80
  } dcmb_state_t;

  // a word access to one command memory
  typedef struct packed {
    logic req;
    logic we;
    logic bank;
    logic [3:0] ofs;
    logic [15:0] wdata;
  } dcmb_mem_req_t;

  // job handed to the engine that does disk or floppy work
  typedef struct packed {
    logic start;
    logic [7:0] op;
    logic [15:0] target;
    logic [15:0] lun;
    logic [15:0] aux;
    logic [31:0] ptr;
    logic [31:0] dst;
  } dcmb_job_t;

  // engine's answer
  typedef struct packed {
    logic done;
    logic [1:0] err;
    logic medium_end;
    logic [15:0] ext_msg;
    logic [31:0] ptr;
  } dcmb_ans_t;

  typedef struct packed {
    dcmb_state_t state;
    logic bank;
    logic [3:0] step;
    logic [15:0] cmd;
    logic [15:0] aux;
    logic [31:0] ptr;
    logic [31:0] dst;
    logic [15:0] lun;
    logic [15:0] status;
    logic [15:0] ext_msg;
    logic [31:0] rptr;
    logic job_start;
    logic mem_req;
    logic mem_we;
    logic [3:0] mem_ofs;
    logic [15:0] mem_wdata;
    logic [4:0] locks;
    logic hash_inval;
    logic prog_call;
    logic [31:0] prog_addr;
    logic pause;
  } dcmb_regs_t;
endpackage

// File: hdl/dcmb_top.sv
// command mailbox interpreter for the disk and floppy controller
`timescale 1ns/100ps
// Notes on behaviour
// - unit query uses word ID, lun at 12
// - unit query returns block pointer at 4
// - status success, address error, parameter error
// - extended error code plus message at 2
// - opcode 50 calls program at address 4
// - backup flushes first in blocking mode
// - backup invalidates hashing buffer contents
// - medium end pauses, flag set, command kept
// - host clears flag, backup resumes
// - host clears command, backup abandoned
// - backup source and destination word order
// - opcode 56 flushes only when buffering
// - opcode 57 formats lun at 12
// - opcode 58 track, pointer, drive number
// - track block geometry and size code
// - track block density and fill pattern
// - interleave selection and lowest sector
// - opcode 59 compares two units
// - opcode 5A locks floppy units by bits
// - locked floppy selection answers not ready
// - opcode 5B releases floppy units
// - leading digit picks memory and status
module dcmb_top (
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic [1:0] CMD_PENDING_IN,
  input wire logic [7:0] OWN_ID_IN,
  input wire logic BLOCKING_MODE_IN,
  input wire logic BUFFERED_WRITE_IN,
  input wire logic MEM_RDY_IN,
  input wire logic [15:0] MEM_RDATA_IN,
  output dcmb_pkg::dcmb_mem_req_t MEM_REQ_OUT,
  output dcmb_pkg::dcmb_job_t JOB_OUT,
  input wire dcmb_pkg::dcmb_ans_t ANS_IN,
  output logic HASH_INVALIDATE_OUT,
  output logic PROG_CALL_OUT,
  output logic [31:0] PROG_ADDR_OUT,
  input wire logic PROG_RETURN_IN,
  output logic [4:0] FLOPPY_LOCKS_OUT,
  input wire logic [2:0] SCSI_SEL_UNIT_IN,
  output logic SCSI_UNIT_NOT_READY_OUT
);
  dcmb_pkg::dcmb_regs_t r_ff;
  dcmb_pkg::dcmb_regs_t nxt_r;

  // bank status base: 8xxx for first memory, 9xxx for second
  function automatic logic [15:0] bank_status(input logic bank, input logic [15:0] code);
    bank_status = bank ? (code | dcmb_pkg::ST_BANK) : code;
  endfunction

  // is a track-format block field plausible
  function automatic logic track_block_ok(input logic [7:0] size_code, input logic [7:0] dens,
                                          input logic [7:0] ilv, input logic [7:0] low_sec);
    track_block_ok = (size_code <= {5'h00, dcmb_pkg::SIZE_CODE_MAX}) && (dens <= dcmb_pkg::DENS_MAX) &&
                     (ilv <= dcmb_pkg::ILV_USER) && (low_sec <= dcmb_pkg::LOW_SEC_MAX);
  endfunction

  logic [7:0] op;
  logic lock_sel;
  assign op = r_ff.cmd[7:0];

  // locked floppy selection over scsi: unit 0 none, 1..4 drives
  always_comb begin
    lock_sel = 1'b0;
    if (SCSI_SEL_UNIT_IN != 3'h0 && SCSI_SEL_UNIT_IN <= 3'(dcmb_pkg::FLOPPY_COUNT)) begin
      lock_sel = r_ff.locks[0] | r_ff.locks[SCSI_SEL_UNIT_IN];
    end
  end
  assign SCSI_UNIT_NOT_READY_OUT = lock_sel;

  // next-state logic of the interpreter
  always_comb begin
    nxt_r = r_ff;
    nxt_r.job_start = 1'b0;
    nxt_r.hash_inval = 1'b0;
    case (r_ff.state)
      dcmb_pkg::ST_IDLE: begin
        nxt_r.mem_req = 1'b0;
        if (CMD_PENDING_IN[0] || CMD_PENDING_IN[1]) begin
          nxt_r.bank = !CMD_PENDING_IN[0];
          nxt_r.step = 4'h0;
          nxt_r.mem_req = 1'b1;
          nxt_r.mem_we = 1'b0;
          nxt_r.mem_ofs = dcmb_pkg::OFS_CMD;
          nxt_r.state = dcmb_pkg::ST_FETCH;
        end
      end
      dcmb_pkg::ST_FETCH: begin
        // read command words 0,2,4,6,8,10,12 in turn
        if (MEM_RDY_IN) begin
          case (r_ff.mem_ofs)
            dcmb_pkg::OFS_CMD: nxt_r.cmd = MEM_RDATA_IN;
            dcmb_pkg::OFS_AUX: nxt_r.aux = MEM_RDATA_IN;
            dcmb_pkg::OFS_PTR: nxt_r.ptr[31:16] = MEM_RDATA_IN;
            dcmb_pkg::OFS_PTR_LO: nxt_r.ptr[15:0] = MEM_RDATA_IN;
            dcmb_pkg::OFS_DST: nxt_r.dst[31:16] = MEM_RDATA_IN;
            dcmb_pkg::OFS_DST_LO: nxt_r.dst[15:0] = MEM_RDATA_IN;
            default: nxt_r.lun = MEM_RDATA_IN;
          endcase
          if (r_ff.mem_ofs == dcmb_pkg::OFS_LUN) begin
            nxt_r.mem_req = 1'b0;
            nxt_r.state = dcmb_pkg::ST_DISPATCH;
          end else begin
            nxt_r.mem_ofs = r_ff.mem_ofs + 4'h2;
          end
        end
      end
      dcmb_pkg::ST_DISPATCH: begin
        nxt_r.ext_msg = 16'h0000;
        nxt_r.rptr = 32'h0000_0000;
        nxt_r.pause = 1'b0;
        nxt_r.status = bank_status(r_ff.bank, dcmb_pkg::ST_OK);
        nxt_r.state = dcmb_pkg::ST_STATUS;
        nxt_r.step = 4'h0;
        case (op)
          dcmb_pkg::OP_LOCK: begin
            if (r_ff.aux[4:0] == 5'h00) begin
              nxt_r.status = bank_status(r_ff.bank, dcmb_pkg::ST_PARAM);
            end else begin
              nxt_r.locks = r_ff.locks | r_ff.aux[4:0];
            end
          end
          dcmb_pkg::OP_RELEASE: begin
            if (r_ff.aux[4:0] == 5'h00) begin
              nxt_r.status = bank_status(r_ff.bank, dcmb_pkg::ST_PARAM);
            end else if (r_ff.aux[0]) begin
              nxt_r.locks = 5'h00;
            end else begin
              nxt_r.locks = r_ff.locks & ~r_ff.aux[4:0];
            end
          end
          dcmb_pkg::OP_RUN_PROG: begin
            if (r_ff.ptr[0]) begin
              nxt_r.status = bank_status(r_ff.bank, dcmb_pkg::ST_ADDR);
            end else begin
              nxt_r.prog_call = 1'b1;
              nxt_r.prog_addr = r_ff.ptr;
              nxt_r.state = dcmb_pkg::ST_WAIT_JOB;
            end
          end
          dcmb_pkg::OP_FLUSH: begin
            if (BUFFERED_WRITE_IN) begin
              nxt_r.job_start = 1'b1;
              nxt_r.state = dcmb_pkg::ST_WAIT_JOB;
            end
          end
          dcmb_pkg::OP_BACKUP: begin
            if (BLOCKING_MODE_IN) begin
              nxt_r.state = dcmb_pkg::ST_FLUSHB;
            end else begin
              nxt_r.job_start = 1'b1;
              nxt_r.hash_inval = 1'b1;
              nxt_r.state = dcmb_pkg::ST_WAIT_JOB;
            end
          end
          dcmb_pkg::OP_FORMAT_FLOPPY_TRACK: begin
            if (r_ff.lun == 16'h0000 || r_ff.lun > 16'(dcmb_pkg::FLOPPY_COUNT) || r_ff.ptr[0]) begin
              nxt_r.status = bank_status(r_ff.bank, r_ff.ptr[0] ? dcmb_pkg::ST_ADDR : dcmb_pkg::ST_PARAM);
            end else begin
              nxt_r.job_start = 1'b1;
              nxt_r.state = dcmb_pkg::ST_WAIT_JOB;
            end
          end
          dcmb_pkg::OP_GET_UNIT, dcmb_pkg::OP_FORMAT, dcmb_pkg::OP_COMPARE: begin
            nxt_r.job_start = 1'b1;
            nxt_r.state = dcmb_pkg::ST_WAIT_JOB;
          end
          default: nxt_r.status = bank_status(r_ff.bank, dcmb_pkg::ST_PARAM);
        endcase
      end
      dcmb_pkg::ST_FLUSHB: begin
        // flush pass before backup, then the copy itself
        if (r_ff.step == 4'h0) begin
          nxt_r.job_start = 1'b1;
          nxt_r.step = 4'h1;
        end else if (ANS_IN.done) begin
          nxt_r.job_start = 1'b1;
          nxt_r.hash_inval = 1'b1;
          nxt_r.step = 4'h0;
          nxt_r.state = dcmb_pkg::ST_WAIT_JOB;
        end
      end
      dcmb_pkg::ST_WAIT_JOB: begin
        if (r_ff.prog_call) begin
          if (PROG_RETURN_IN) begin
            nxt_r.prog_call = 1'b0;
            nxt_r.state = dcmb_pkg::ST_RESULT;
          end
        end else if (ANS_IN.done) begin
          nxt_r.rptr = ANS_IN.ptr;
          nxt_r.ext_msg = ANS_IN.ext_msg;
          case (ANS_IN.err)
            2'h1: nxt_r.status = bank_status(r_ff.bank, dcmb_pkg::ST_ADDR);
            2'h2: nxt_r.status = bank_status(r_ff.bank, dcmb_pkg::ST_PARAM);
            2'h3: nxt_r.status = bank_status(r_ff.bank, dcmb_pkg::ST_EXT);
            default: nxt_r.status = bank_status(r_ff.bank, dcmb_pkg::ST_OK);
          endcase
          // medium end latched here so the status write does not depend on a live input
          nxt_r.pause = (op == dcmb_pkg::OP_BACKUP) && ANS_IN.medium_end;
          if (op == dcmb_pkg::OP_BACKUP && ANS_IN.medium_end) begin
            nxt_r.status = bank_status(r_ff.bank, dcmb_pkg::ST_PAUSE | {8'h00, op});
          end
          nxt_r.state = dcmb_pkg::ST_RESULT;
        end
      end
      dcmb_pkg::ST_RESULT: begin
        // result words: message at 2, pointer at 4 and 6
        nxt_r.mem_req = 1'b1;
        nxt_r.mem_we = 1'b1;
        if (r_ff.mem_req && MEM_RDY_IN) begin
          nxt_r.step = r_ff.step + 4'h1;
        end
        case (nxt_r.step)
          4'h0: begin
            nxt_r.mem_ofs = dcmb_pkg::OFS_AUX;
            nxt_r.mem_wdata = r_ff.ext_msg;
          end
          4'h1: begin
            nxt_r.mem_ofs = dcmb_pkg::OFS_PTR;
            nxt_r.mem_wdata = r_ff.rptr[31:16];
          end
          4'h2: begin
            nxt_r.mem_ofs = dcmb_pkg::OFS_PTR_LO;
            nxt_r.mem_wdata = r_ff.rptr[15:0];
          end
          default: begin
            nxt_r.mem_req = 1'b0;
            nxt_r.step = 4'h0;
            nxt_r.state = dcmb_pkg::ST_STATUS;
          end
        endcase
      end
      dcmb_pkg::ST_STATUS: begin
        // status word last so host sees complete results
        nxt_r.mem_req = 1'b1;
        nxt_r.mem_we = 1'b1;
        nxt_r.mem_ofs = dcmb_pkg::OFS_CMD;
        nxt_r.mem_wdata = r_ff.status;
        if (r_ff.mem_req && MEM_RDY_IN) begin
          nxt_r.mem_req = 1'b0;
          nxt_r.mem_we = 1'b0;
          if (r_ff.pause) begin
            nxt_r.state = dcmb_pkg::ST_PAUSED;
          end else begin
            nxt_r.state = dcmb_pkg::ST_IDLE;
          end
        end
      end
      dcmb_pkg::ST_PAUSED: begin
        // poll the status word for flag reset or code clear
        nxt_r.mem_req = 1'b1;
        nxt_r.mem_we = 1'b0;
        nxt_r.mem_ofs = dcmb_pkg::OFS_CMD;
        if (r_ff.mem_req && MEM_RDY_IN) begin
          if (MEM_RDATA_IN[7:0] == 8'h00) begin
            nxt_r.mem_req = 1'b0;
            nxt_r.state = dcmb_pkg::ST_IDLE;
          end else if (!MEM_RDATA_IN[15]) begin
            nxt_r.mem_req = 1'b0;
            nxt_r.job_start = 1'b1;
            nxt_r.state = dcmb_pkg::ST_WAIT_JOB;
          end
        end
      end
      default: nxt_r.state = dcmb_pkg::ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      r_ff <= '{state: dcmb_pkg::ST_IDLE, default: '0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  // outputs
  always_comb begin
    MEM_REQ_OUT.req = r_ff.mem_req;
    MEM_REQ_OUT.we = r_ff.mem_we;
    MEM_REQ_OUT.bank = r_ff.bank;
    MEM_REQ_OUT.ofs = r_ff.mem_ofs;
    MEM_REQ_OUT.wdata = r_ff.mem_wdata;
    JOB_OUT.start = r_ff.job_start;
    JOB_OUT.op = (r_ff.state == dcmb_pkg::ST_FLUSHB) ? dcmb_pkg::OP_FLUSH : op;
    JOB_OUT.target = (op == dcmb_pkg::OP_BACKUP) ? r_ff.ptr[31:16] : {8'h00, r_ff.cmd[15:8]};
    JOB_OUT.lun = (op == dcmb_pkg::OP_BACKUP) ? r_ff.ptr[15:0] : r_ff.lun;
    JOB_OUT.aux = r_ff.aux;
    JOB_OUT.ptr = r_ff.ptr;
    JOB_OUT.dst = (op == dcmb_pkg::OP_BACKUP) ? {r_ff.dst[15:0], r_ff.dst[31:16]} : r_ff.dst;
  end
  assign HASH_INVALIDATE_OUT = r_ff.hash_inval;
  assign PROG_CALL_OUT = r_ff.prog_call;
  assign PROG_ADDR_OUT = r_ff.prog_addr;
  assign FLOPPY_LOCKS_OUT = r_ff.locks;
endmodule

// File: dv/dcmb_partner.sv
// host-side command memory model for both mailboxes
`timescale 1ns/100ps
module dcmb_partner (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire dcmb_pkg::dcmb_mem_req_t req_in,
  input wire logic [1:0] dly_in,
  output logic rdy_out,
  output logic [15:0] rdata_out
);
  logic [15:0] mem [0:15];
  logic [1:0] cnt;
  // one-cycle ready after a variable delay; idle data keeps toggling
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdy_out <= 1'b0;
      cnt <= 2'h0;
      rdata_out <= 16'h0000;
    end else if (rdy_out || !req_in.req) begin
      rdy_out <= 1'b0;
      cnt <= dly_in;
      rdata_out <= ~rdata_out;
    end else if (cnt != 2'h0) begin
      cnt <= cnt - 2'h1;
    end else begin
      rdy_out <= 1'b1;
      rdata_out <= mem[{req_in.bank, req_in.ofs[3:1]}];
      if (req_in.we) begin
        mem[{req_in.bank, req_in.ofs[3:1]}] <= req_in.wdata;
      end
    end
  end
endmodule

// File: dv/dcmb_checker.sv
// port-level assertions on the mailbox interpreter
`timescale 1ns/100ps
module dcmb_checker (
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic MEM_RDY_IN,
  input wire dcmb_pkg::dcmb_mem_req_t MEM_REQ_OUT,
  input wire dcmb_pkg::dcmb_job_t JOB_OUT,
  input wire logic HASH_INVALIDATE_OUT,
  input wire logic PROG_CALL_OUT,
  input wire logic [31:0] PROG_ADDR_OUT,
  input wire logic PROG_RETURN_IN,
  input wire logic [4:0] FLOPPY_LOCKS_OUT,
  input wire logic [2:0] SCSI_SEL_UNIT_IN,
  input wire logic SCSI_UNIT_NOT_READY_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  property p_req_hold;
    MEM_REQ_OUT.req && !MEM_RDY_IN |=> MEM_REQ_OUT.req && $stable(MEM_REQ_OUT);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("memory request dropped early");
  property p_status_code;
    MEM_REQ_OUT.req && MEM_REQ_OUT.we && MEM_REQ_OUT.ofs == dcmb_pkg::OFS_CMD
      |-> MEM_REQ_OUT.wdata[15] && MEM_REQ_OUT.wdata[14:13] == 2'h0 && MEM_REQ_OUT.wdata[11:8] == 4'h0 &&
          (MEM_REQ_OUT.wdata[7:4] == 4'h0 || MEM_REQ_OUT.wdata[7:0] == dcmb_pkg::OP_BACKUP);
  endproperty
  a_status_code: assert property (p_status_code) else $error("bad status code");
  property p_start_pulse;
    JOB_OUT.start |=> !JOB_OUT.start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("job start too long");
  property p_hash_pulse;
    HASH_INVALIDATE_OUT |=> !HASH_INVALIDATE_OUT;
  endproperty
  a_hash_pulse: assert property (p_hash_pulse) else $error("hash pulse too long");
  property p_locked;
    SCSI_SEL_UNIT_IN != 3'h0 && SCSI_SEL_UNIT_IN <= 3'h4
      |-> SCSI_UNIT_NOT_READY_OUT == (FLOPPY_LOCKS_OUT[0] | FLOPPY_LOCKS_OUT[SCSI_SEL_UNIT_IN]);
  endproperty
  a_locked: assert property (p_locked) else $error("not-ready answer wrong");
  property p_unsel;
    SCSI_SEL_UNIT_IN == 3'h0 || SCSI_SEL_UNIT_IN > 3'h4 |-> !SCSI_UNIT_NOT_READY_OUT;
  endproperty
  a_unsel: assert property (p_unsel) else $error("not-ready without selection");
  property p_prog_hold;
    PROG_CALL_OUT && !PROG_RETURN_IN |=> PROG_CALL_OUT && $stable(PROG_ADDR_OUT);
  endproperty
  a_prog_hold: assert property (p_prog_hold) else $error("program call dropped");
  property p_prog_even;
    PROG_CALL_OUT |-> !PROG_ADDR_OUT[0];
  endproperty
  a_prog_even: assert property (p_prog_even) else $error("odd program address called");
  c_job: cover property (JOB_OUT.start);
  c_hash: cover property (HASH_INVALIDATE_OUT);
  c_prog: cover property (PROG_CALL_OUT && PROG_RETURN_IN);
  c_nrdy: cover property (SCSI_UNIT_NOT_READY_OUT);
endmodule
bind dcmb_top dcmb_checker i_dcmb_checker (.CLK_IN, .SYS_RST_IN, .MEM_RDY_IN, .MEM_REQ_OUT, .JOB_OUT,
  .HASH_INVALIDATE_OUT, .PROG_CALL_OUT, .PROG_ADDR_OUT, .PROG_RETURN_IN, .FLOPPY_LOCKS_OUT,
  .SCSI_SEL_UNIT_IN, .SCSI_UNIT_NOT_READY_OUT);

// File: dv/tb_disk_unit_command_mailbox.sv
// self-checking bench for the command mailbox interpreter
`timescale 1ns/100ps
module tb_disk_unit_command_mailbox;
  logic CLK_IN, SYS_RST_IN, BLOCKING_MODE_IN, BUFFERED_WRITE_IN, MEM_RDY_IN, PROG_RETURN_IN;
  logic HASH_INVALIDATE_OUT, PROG_CALL_OUT, SCSI_UNIT_NOT_READY_OUT;
  logic [1:0] CMD_PENDING_IN, dly;
  logic [2:0] SCSI_SEL_UNIT_IN;
  logic [4:0] FLOPPY_LOCKS_OUT;
  logic [7:0] OWN_ID_IN;
  logic [15:0] MEM_RDATA_IN, lv;
  logic [31:0] PROG_ADDR_OUT, last_paddr;
  logic [31:0] rng = 32'hE45E;
  dcmb_pkg::dcmb_mem_req_t MEM_REQ_OUT;
  dcmb_pkg::dcmb_job_t JOB_OUT, lj;
  dcmb_pkg::dcmb_ans_t ANS_IN, ans_next;
  int n_errors = 0, checks = 0, n_status = 0, n_hash = 0, cnt = 0, pcnt = 0;
  logic [15:0] exp_q[$];
  logic [7:0] job_q[$];
  dcmb_top i_dcmb_top (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .CMD_PENDING_IN(CMD_PENDING_IN),
    .OWN_ID_IN(OWN_ID_IN), .BLOCKING_MODE_IN(BLOCKING_MODE_IN), .BUFFERED_WRITE_IN(BUFFERED_WRITE_IN),
    .MEM_RDY_IN(MEM_RDY_IN), .MEM_RDATA_IN(MEM_RDATA_IN), .MEM_REQ_OUT(MEM_REQ_OUT), .JOB_OUT(JOB_OUT),
    .ANS_IN(ANS_IN), .HASH_INVALIDATE_OUT(HASH_INVALIDATE_OUT), .PROG_CALL_OUT(PROG_CALL_OUT),
    .PROG_ADDR_OUT(PROG_ADDR_OUT), .PROG_RETURN_IN(PROG_RETURN_IN), .FLOPPY_LOCKS_OUT(FLOPPY_LOCKS_OUT),
    .SCSI_SEL_UNIT_IN(SCSI_SEL_UNIT_IN), .SCSI_UNIT_NOT_READY_OUT(SCSI_UNIT_NOT_READY_OUT));
  dcmb_partner i_dcmb_partner (.clk_in(CLK_IN), .rst_in(SYS_RST_IN), .req_in(MEM_REQ_OUT), .dly_in(dly),
    .rdy_out(MEM_RDY_IN), .rdata_out(MEM_RDATA_IN));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report();
    $display("mismatches %0d comparisons %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // load one mailbox, command word last, then wait for its status
  task automatic run(input logic b, input logic [15:0] c, a, w4, w6, w8, w10, w12, st);
    int s;
    int i;
    i_dcmb_partner.mem[{b, 3'h1}] = a;
    i_dcmb_partner.mem[{b, 3'h2}] = w4;
    i_dcmb_partner.mem[{b, 3'h3}] = w6;
    i_dcmb_partner.mem[{b, 3'h4}] = w8;
    i_dcmb_partner.mem[{b, 3'h5}] = w10;
    i_dcmb_partner.mem[{b, 3'h6}] = w12;
    i_dcmb_partner.mem[{b, 3'h0}] = c;
    exp_q.push_back(st);
    s = n_status;
    CMD_PENDING_IN[b] = 1'b1;
    for (i = 0; i < 200 && MEM_RDY_IN !== 1'b1; i++) @(negedge CLK_IN);
    if (i == 200) begin
      n_errors++;
      final_report();
    end
    CMD_PENDING_IN = 2'h0;
    for (i = 0; i < 2000 && n_status == s; i++) @(negedge CLK_IN);
    if (i == 2000) begin
      n_errors++;
      final_report();
    end
    $display("test %h ends", c);
  endtask
  // host rewrites the status word of a paused mailbox, then waits for the next status
  task automatic poke(input logic [15:0] c, input logic [15:0] st);
    int s;
    int i;
    s = n_status;
    exp_q.push_back(st);
    i_dcmb_partner.mem[0] = c;
    for (i = 0; i < 2000 && n_status == s; i++) @(negedge CLK_IN);
    if (i == 2000) begin
      n_errors++;
      final_report();
    end
    $display("test %h ends", c);
  endtask
  // clock
  initial begin
    CLK_IN = 1'b0;
    forever #2.5 CLK_IN = ~CLK_IN;
  end
  // status writes checked against the oldest expectation
  always @(posedge CLK_IN) begin
    if (HASH_INVALIDATE_OUT === 1'b1) n_hash++;
    if (!SYS_RST_IN && MEM_REQ_OUT.req && MEM_REQ_OUT.we && MEM_RDY_IN
        && MEM_REQ_OUT.ofs === dcmb_pkg::OFS_CMD) begin
      n_status++;
      if (exp_q.size() == 0) chk("spare status", 0, 1);
      else chk("status", exp_q.pop_front(), MEM_REQ_OUT.wdata);
    end
  end
  // engine and user-program responder, fixed answer delay
  always @(negedge CLK_IN) begin
    rng <= xs(rng);
    dly <= rng[1:0];
    ANS_IN <= (cnt == 1) ? ans_next : '0;
    if (JOB_OUT.start === 1'b1) begin
      job_q.push_back(JOB_OUT.op);
      lj <= JOB_OUT;
      cnt <= 3;
    end else if (cnt > 0) cnt <= cnt - 1;
    PROG_RETURN_IN <= (PROG_CALL_OUT === 1'b1 && pcnt == 4);
    pcnt <= (PROG_CALL_OUT === 1'b1) ? pcnt + 1 : 0;
    if (PROG_CALL_OUT === 1'b1) last_paddr <= PROG_ADDR_OUT;
  end
  initial begin
    {CMD_PENDING_IN, BLOCKING_MODE_IN, BUFFERED_WRITE_IN, SCSI_SEL_UNIT_IN} = '0;
    OWN_ID_IN = 8'h07;
    ans_next = '0;
    SYS_RST_IN = 1'b1;
    repeat (5) @(negedge CLK_IN);
    SYS_RST_IN = 1'b0;
    chk("locks at reset", 5'h00, FLOPPY_LOCKS_OUT);
    run(0, 16'h005A, 16'h0006, 0, 0, 0, 0, 0, dcmb_pkg::ST_OK);
    chk("locks", 5'h06, FLOPPY_LOCKS_OUT);
    for (int u = 0; u < 6; u++) begin
      SCSI_SEL_UNIT_IN = u[2:0];
      @(negedge CLK_IN);
      chk("not ready", u == 1 || u == 2, SCSI_UNIT_NOT_READY_OUT);
    end
    run(1, 16'h105B, 16'h0002, 0, 0, 0, 0, 0, dcmb_pkg::ST_OK | dcmb_pkg::ST_BANK);
    chk("locks", 5'h04, FLOPPY_LOCKS_OUT);
    run(0, 16'h005A, 16'h0000, 0, 0, 0, 0, 0, dcmb_pkg::ST_PARAM);
    run(0, 16'h007F, 0, 0, 0, 0, 0, 0, dcmb_pkg::ST_PARAM);
    // program placed in an I/O buffer at a local address
    run(0, 16'h0050, 0, 16'h0000, 16'h2000, 0, 0, 0, dcmb_pkg::ST_OK);
    chk("program address", 32'h00002000, last_paddr);
    run(0, 16'h0050, 0, 16'h0000, 16'h2001, 0, 0, 0, dcmb_pkg::ST_ADDR);
    ans_next = {1'b1, 2'h0, 1'b0, rng[15:0], xs(rng)};
    lv = rng[31:16];
    run(0, 16'h0346, 0, 0, 0, 0, 0, lv, dcmb_pkg::ST_OK);
    chk("unit op", dcmb_pkg::OP_GET_UNIT, job_q.pop_front());
    chk("unit lun", lv, lj.lun);
    chk("result pointer", ans_next.ptr, {i_dcmb_partner.mem[2], i_dcmb_partner.mem[3]});
    ans_next = {1'b1, 2'h3, 1'b0, rng[15:0], 32'h0};
    run(0, 16'h0057, 0, 0, 0, 0, 0, 16'h0002, dcmb_pkg::ST_EXT);
    chk("format op", dcmb_pkg::OP_FORMAT, job_q.pop_front());
    chk("ext message", ans_next.ext_msg, i_dcmb_partner.mem[1]);
    ans_next = {1'b1, 2'h0, 1'b0, 16'h0, 32'h0};
    for (int w = 0; w < 2; w++) begin
      BUFFERED_WRITE_IN = w[0];
      run(0, 16'h0056, 0, 0, 0, 0, 0, 0, dcmb_pkg::ST_OK);
      chk("flush jobs", w, job_q.size());
      job_q.delete();
    end
    BLOCKING_MODE_IN = 1'b1;
    run(0, 16'h0055, 0, 16'h0005, 16'h0003, 16'h0003, 16'h0005, 0, dcmb_pkg::ST_OK);
    chk("backup jobs", 2, job_q.size());
    chk("first job", dcmb_pkg::OP_FLUSH, job_q[0]);
    chk("copy job", dcmb_pkg::OP_BACKUP, job_q[1]);
    chk("hash pulses", 1, n_hash);
    chk("source", 32'h00050003, {lj.target, lj.lun});
    chk("destination", 32'h00050003, lj.dst);
    // medium end pause, then resume by flag reset
    BLOCKING_MODE_IN = 1'b0;
    ans_next.medium_end = 1'b1;
    run(0, 16'h0055, 0, 16'h0005, 16'h0003, 16'h0003, 16'h0005, 0, dcmb_pkg::ST_PAUSE | 16'h0055);
    ans_next.medium_end = 1'b0;
    poke(16'h0055, dcmb_pkg::ST_OK);
    // pause again, then cancel by clearing the command code
    ans_next.medium_end = 1'b1;
    run(0, 16'h0055, 0, 16'h0005, 16'h0003, 16'h0003, 16'h0005, 0, dcmb_pkg::ST_PAUSE | 16'h0055);
    ans_next.medium_end = 1'b0;
    job_q.delete();
    i_dcmb_partner.mem[0] = 16'h8000;
    repeat (20) @(negedge CLK_IN);
    chk("cancel jobs", 0, job_q.size());
    run(0, 16'h005A, 16'h0001, 0, 0, 0, 0, 0, dcmb_pkg::ST_OK);
    chk("locks all", 5'h05, FLOPPY_LOCKS_OUT);
    final_report();
  end
endmodule
